// File: logic/msfr_pkg.sv
// constants, register map and carrier types for the multichip sync and
// frame reset block; shared by the design and the bench
package msfr_pkg;
  // register port widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  // register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_CMD = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h02;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h03;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h04;
  // control field positions
  localparam int CTRL_SYNC_EN = 0;
  localparam int CTRL_EDGE_RISE = 1;
  localparam int CTRL_CONTINUOUS = 2;
  localparam int CTRL_BYTE_MODE = 3;
  localparam int CMD_FIFO_RST = 0;
  // event bit positions in mask and sticky registers; status holds only the first two
  localparam int EV_SYNC_DONE = 0;
  localparam int EV_LOCK_LOST = 1;
  localparam int EV_FIFO_RST = 2;
  localparam int EV_W = 3;
  // reset values
  localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [EV_W-1:0] MASK_RESET = 3'h0;
  // internal divider and fifo model
  localparam int PHASE_W = 6;
  localparam logic [PHASE_W-1:0] PHASE_ZERO = 6'h00;
  localparam logic [PHASE_W-1:0] PHASE_ONE = 6'h01;
  localparam logic [2:0] RD_SLOT = 3'h7;
  localparam int PTR_W = 4;
  localparam logic [PTR_W-1:0] PTR_ONE = 4'h1;
  localparam logic [PTR_W-1:0] FIFO_NOMINAL = 4'h4;
  // frame pulse must outlast these interface clock cycles
  localparam logic [1:0] FRAME_MIN_WORD = 2'h1;
  localparam logic [1:0] FRAME_MIN_BYTE = 2'h2;
  localparam logic [1:0] CNT_ONE = 2'h1;
  // worst-case alignment slack without the sync engine, in sample cycles
  localparam int MAX_SKEW_CYC = 2;

  // software controls
  typedef struct packed {
    logic byte_mode;
    logic continuous;
    logic edge_rise;
    logic sync_en;
  } msfr_ctrl_t;

  // status seen by software
  typedef struct packed {
    logic [PTR_W-1:0] fifo_level;
    logic lock_lost;
    logic sync_done;
  } msfr_stat_t;

  // sync sequencer states
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_ARM = 4'b0010,
    S_ALIGN = 4'b0100,
    S_LOCK = 4'b1000
  } msfr_state_t;
endpackage

// File: logic/msfr_core.sv
// multichip sync and frame reset engine with register port and interrupt
// assumes one 10 MHz clock; interface clock, sync reference and frame all
// arrive asynchronously and are sampled here
//
// Summary of operation
// - with sync off, latency varies at most two sample cycles per power-up
// - synchronized means equal clock phase, fifo level and data alignment
// - interface clock edge aligns fifo level and internal phase
// - sub-cycle alignment needs sync engine, sync reference and frame
// - sample clock samples sync reference, giving the divider reset point
// - continuous mode resets fifo and sync engine on every frame
// - one-shot mode syncs on first valid frame then ignores later ones
// - software selects rising or falling capture edge; falling by default
// - with sync on, a frame pulse or frame clock resets the input fifo; with sync off only software does
`timescale 1ns/1ps
module msfr_core (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [msfr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [msfr_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [msfr_pkg::DATA_W-1:0] reg_rdata,
  // asynchronous link inputs
  input wire logic data_interface_clock,
  input wire logic sync_reference_clock,
  input wire logic frame_in,
  // results
  output logic fifo_rst_o,
  output logic [msfr_pkg::PHASE_W-1:0] clk_phase_o,
  output logic irq
);
  import msfr_pkg::*;

  // two-stage synchronisers; interface clock and sync reference add an edge-detect stage
  logic dci_s1_r, dci_s2_r, dci_s3_r;
  logic syn_s1_r, syn_s2_r, syn_s3_r;
  logic frm_s1_r, frm_s2_r;
  logic sync_rise_d_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      dci_s1_r <= 1'b0;
      dci_s2_r <= 1'b0;
      dci_s3_r <= 1'b0;
      syn_s1_r <= 1'b0;
      syn_s2_r <= 1'b0;
      syn_s3_r <= 1'b0;
      frm_s1_r <= 1'b0;
      frm_s2_r <= 1'b0;
      sync_rise_d_r <= 1'b0;
    end else begin
      dci_s1_r <= data_interface_clock;
      dci_s2_r <= dci_s1_r;
      dci_s3_r <= dci_s2_r;
      syn_s1_r <= sync_reference_clock;
      syn_s2_r <= syn_s1_r;
      syn_s3_r <= syn_s2_r;
      frm_s1_r <= frame_in;
      frm_s2_r <= frm_s1_r;
      sync_rise_d_r <= syn_s2_r & ~syn_s3_r;
    end
  end

  // registers and state
  msfr_ctrl_t ctrl_r;
  logic [EV_W-1:0] mask_r, ev_stat_r;
  msfr_state_t state_r, state_nxt;
  logic [PHASE_W-1:0] phase_r;
  logic [PTR_W-1:0] wr_ptr_r, rd_ptr_r;
  logic [1:0] frm_cnt_r;
  logic sync_done_r, lock_lost_r, sw_align_r;
  logic [DATA_W-1:0] rdata_r;
  logic fifo_rst_r, irq_r;

  // edge and strobe decode
  wire dci_edge = dci_s2_r & ~dci_s3_r;
  wire sync_rise = syn_s2_r & ~syn_s3_r;
  // the falling-edge option captures half a sample period later, modelled
  // here as one cycle later since only one clock edge exists
  wire sync_hit = ctrl_r.edge_rise ? sync_rise : sync_rise_d_r;
  wire [1:0] frm_min = ctrl_r.byte_mode ? FRAME_MIN_BYTE : FRAME_MIN_WORD;
  // frame counts as valid once it outlasted the minimum width
  wire frame_valid = frm_s2_r & dci_edge & (frm_cnt_r == frm_min);
  wire wr_ctrl = reg_wr & (reg_addr == ADDR_CTRL);
  wire wr_mask = reg_wr & (reg_addr == ADDR_IRQ_MASK);
  wire sw_fifo_rst = reg_wr & (reg_addr == ADDR_CMD) &
                     reg_wdata[CMD_FIFO_RST];
  wire rd_stat = reg_rd & (reg_addr == ADDR_IRQ_STAT);

  // sequencer decode
  wire in_idle = (state_r == S_IDLE);
  wire in_arm = (state_r == S_ARM);
  wire in_align = (state_r == S_ALIGN);
  wire in_lock = (state_r == S_LOCK);
  // one-shot ignores frames once locked, continuous restarts on each
  wire frame_take = frame_valid &
                    (in_arm | (in_lock & ctrl_r.continuous));
  wire align_now = in_align & sync_hit;
  // at a matching sync hit the divider is about to wrap, so the phase it
  // takes next is zero; anything else means the ratio slipped
  wire [PHASE_W-1:0] phase_inc = phase_r + PHASE_ONE;
  wire lock_slip = in_lock & sync_hit & (phase_inc != PHASE_ZERO);
  wire fifo_rst_nxt = frame_take | sw_fifo_rst;
  wire [EV_W-1:0] ev_now = {fifo_rst_nxt, lock_slip, align_now};
  wire [PTR_W-1:0] level = wr_ptr_r - rd_ptr_r;
  msfr_stat_t stat;
  assign stat = '{fifo_level: level, lock_lost: lock_lost_r,
                  sync_done: sync_done_r};

  // next state of the sync sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: begin
        if (ctrl_r.sync_en) begin
          state_nxt = S_ARM;
        end
      end
      S_ARM: begin
        if (!ctrl_r.sync_en) begin
          state_nxt = S_IDLE;
        end else if (frame_take) begin
          state_nxt = S_ALIGN;
        end
      end
      S_ALIGN: begin
        if (!ctrl_r.sync_en) begin
          state_nxt = S_IDLE;
        end else if (align_now) begin
          state_nxt = S_LOCK;
        end
      end
      S_LOCK: begin
        if (!ctrl_r.sync_en) begin
          state_nxt = S_IDLE;
        end else if (frame_take) begin
          state_nxt = S_ALIGN;
        end
      end
      default: state_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= S_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // frame width counter, counts interface clock edges while frame is high
  always_ff @(posedge clk) begin
    if (rst || !frm_s2_r) begin
      frm_cnt_r <= 2'h0;
    end else if (dci_edge && frm_cnt_r != frm_min) begin
      frm_cnt_r <= frm_cnt_r + CNT_ONE;
    end
  end

  // internal divider phase: sync reference resets it when the engine runs,
  // otherwise the interface clock edge after a fifo reset does
  always_ff @(posedge clk) begin
    if (rst) begin
      phase_r <= PHASE_ZERO;
      sw_align_r <= 1'b0;
    end else begin
      if (align_now || (sw_align_r && dci_edge)) begin
        phase_r <= PHASE_ZERO;
      end else begin
        phase_r <= phase_inc;
      end
      if (sw_fifo_rst && in_idle) begin
        sw_align_r <= 1'b1;
      end else if (dci_edge) begin
        sw_align_r <= 1'b0;
      end
    end
  end

  // fifo level model: written per interface edge, read every eighth cycle;
  // reset puts the read pointer a fixed depth behind the write pointer
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_r <= PTR_W'(0);
      rd_ptr_r <= PTR_W'(0) - FIFO_NOMINAL;
    end else begin
      if (dci_edge) begin
        wr_ptr_r <= wr_ptr_r + PTR_ONE;
      end
      if (fifo_rst_nxt) begin
        rd_ptr_r <= wr_ptr_r - FIFO_NOMINAL;
      end else if (phase_r[2:0] == RD_SLOT) begin
        rd_ptr_r <= rd_ptr_r + PTR_ONE;
      end
    end
  end

  // sync status; lock loss stays until the next alignment
  always_ff @(posedge clk) begin
    if (rst) begin
      sync_done_r <= 1'b0;
      lock_lost_r <= 1'b0;
    end else if (align_now) begin
      sync_done_r <= 1'b1;
      lock_lost_r <= 1'b0;
    end else begin
      if (frame_take || !ctrl_r.sync_en) begin
        sync_done_r <= 1'b0;
      end
      if (lock_slip) begin
        lock_lost_r <= 1'b1;
      end
    end
  end

  // software registers
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_r <= msfr_ctrl_t'(CTRL_RESET[3:0]);
      mask_r <= MASK_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= msfr_ctrl_t'(reg_wdata[3:0]);
      end
      if (wr_mask) begin
        mask_r <= reg_wdata[EV_W-1:0];
      end
    end
  end

  // sticky events: a read clears, but a new event in that cycle still sets
  always_ff @(posedge clk) begin
    if (rst) begin
      ev_stat_r <= '0;
    end else if (rd_stat) begin
      ev_stat_r <= ev_now;
    end else begin
      ev_stat_r <= ev_stat_r | ev_now;
    end
  end

  // read data mux, valid the cycle after the read strobe
  logic [DATA_W-1:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    if (reg_addr == ADDR_CTRL) begin
      rd_mux = {4'h0, ctrl_r};
    end else if (reg_addr == ADDR_STATUS) begin
      rd_mux = {2'h0, stat};
    end else if (reg_addr == ADDR_IRQ_STAT) begin
      rd_mux = {5'h00, ev_stat_r};
    end else if (reg_addr == ADDR_IRQ_MASK) begin
      rd_mux = {5'h00, mask_r};
    end
  end

  // registered outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_r <= '0;
      fifo_rst_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      rdata_r <= reg_rd ? rd_mux : '0;
      fifo_rst_r <= fifo_rst_nxt;
      irq_r <= |(ev_stat_r & mask_r);
    end
  end

  assign reg_rdata = rdata_r;
  assign fifo_rst_o = fifo_rst_r;
  assign clk_phase_o = phase_r;
  assign irq = irq_r;

  // checks
  // a frame taken while armed
  sequence frame_seen;
    in_arm && frame_valid;
  endsequence

  // the pulse and the level the reset leaves, seen together; a cycle later
  // the read slot may already have moved the level
  sequence fifo_pulse;
    fifo_rst_o && (level == FIFO_NOMINAL || level == FIFO_NOMINAL + PTR_ONE);
  endsequence

  a_frame_resets_fifo: assert property (@(posedge clk) disable iff (rst)
    frame_seen |=> fifo_pulse)
    else $error("valid frame did not reset fifo to nominal level");

  a_align_phase_zero: assert property (@(posedge clk) disable iff (rst)
    align_now |=> (phase_r == PHASE_ZERO) ##1 (phase_r == PHASE_ONE))
    else $error("sync hit did not restart divider phase");

  a_oneshot_ignores: assert property (@(posedge clk) disable iff (rst)
    (in_lock && ctrl_r.sync_en && !ctrl_r.continuous && frame_valid &&
     !sw_fifo_rst)
      |=> !fifo_rst_o && in_lock)
    else $error("one-shot mode acted on a later frame");

  a_continuous_rearm: assert property (@(posedge clk) disable iff (rst)
    (in_lock && ctrl_r.continuous && frame_valid && ctrl_r.sync_en)
      |=> in_align && fifo_rst_o && !sync_done_r)
    else $error("continuous mode missed a frame reset");

  a_edge_falling_lag: assert property (@(posedge clk) disable iff (rst)
    (!ctrl_r.edge_rise && sync_rise && !wr_ctrl)
      |-> !sync_hit ##1 sync_hit)
    else $error("falling capture option not one cycle late");

  a_sw_phase_align: assert property (@(posedge clk) disable iff (rst)
    (sw_fifo_rst && in_idle) |-> ##[1:20] (phase_r == PHASE_ZERO))
    else $error("interface clock did not realign phase after fifo reset");

  a_lock_lost_flag: assert property (@(posedge clk) disable iff (rst)
    lock_slip |=> (lock_lost_r && ev_stat_r[EV_LOCK_LOST]))
    else $error("phase slip not reported as lock lost");

  a_irq_level: assert property (@(posedge clk) disable iff (rst)
    irq == $past(|(ev_stat_r & mask_r)))
    else $error("interrupt output does not follow masked events");

  a_read_set_wins: assert property (@(posedge clk) disable iff (rst)
    (rd_stat && ev_now[EV_FIFO_RST]) |=> ev_stat_r[EV_FIFO_RST])
    else $error("event lost in the cycle of its clearing read");

  // the answer cycle is the only one in which read data may be non-zero
  a_rdata_one_cycle: assert property (@(posedge clk) disable iff (rst)
    !$past(reg_rd) |-> (reg_rdata == '0))
    else $error("read data stood outside its answer cycle");

  // an interface edge after a software fifo reset restarts the divider
  a_link_edge_align: assert property (@(posedge clk) disable iff (rst)
    (sw_align_r && dci_edge) |=> (phase_r == PHASE_ZERO))
    else $error("interface edge did not restart divider phase");
endmodule

// File: tb/msfr_src.sv
// far-side model: interface clock, sync reference and frame source
// assumes the block samples all three lines asynchronously
`timescale 1ns/1ps
module msfr_src (
  // controls from the bench
  frame_cont,
  sync_fast,
  // link lines
  data_interface_clock,
  sync_reference_clock,
  frame
);
  input wire logic frame_cont;
  input wire logic sync_fast;
  output logic data_interface_clock;
  output logic sync_reference_clock;
  output logic frame;
  logic [2:0] div_r = 3'h0;
  logic one_r = 1'b0;
  // free interface clock; the odd start keeps its phase unrelated to clk
  initial begin
    data_interface_clock = 1'b0;
    #137;
    forever #400 data_interface_clock = ~data_interface_clock;
  end
  always @(posedge data_interface_clock) begin
    div_r <= div_r + 3'h1;
  end
  // sync at a eighth of the interface clock; a quarter only for a bad ratio
  assign sync_reference_clock = sync_fast ? div_r[1] : div_r[2];
  // continuous frame is high 4 of 8 interface cycles
  assign frame = one_r | (frame_cont & div_r[2]);
  // one-shot pulse held len interface cycles, above the minimum width
  task automatic one_frame(input int len);
    @(posedge data_interface_clock);
    one_r <= 1'b1;
    repeat (len) @(posedge data_interface_clock);
    one_r <= 1'b0;
  endtask
endmodule

// File: tb/tb_msfr_core.sv
// testbench for the sync and frame reset block: register port tasks,
// far-side model on the link lines, scripted checks
`timescale 1ns/1ps
module tb_msfr_core;
  import msfr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = 8'h00;
  logic [DATA_W-1:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic link_clk, sref, frame_in, fifo_rst_o, irq;
  logic [PHASE_W-1:0] clk_phase_o;
  logic frame_cont = 1'b0;
  logic sync_fast = 1'b0;
  int mismatches = 0;
  int checks_done = 0;
  int k;
  int n0;
  logic [7:0] d;
  logic [7:0] acc;
  // design under test and its far side
  msfr_core uut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .data_interface_clock(link_clk),
    .sync_reference_clock(sref), .frame_in(frame_in),
    .fifo_rst_o(fifo_rst_o), .clk_phase_o(clk_phase_o), .irq(irq));
  msfr_src src (.frame_cont(frame_cont), .sync_fast(sync_fast),
    .data_interface_clock(link_clk), .sync_reference_clock(sref),
    .frame(frame_in));
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string msg);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  // one-cycle write strobe; the leading edge keeps strobes apart
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] m,
                        input logic [7:0] exp, input string msg);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    chk(reg_rdata & m, exp, msg);
  endtask
  // plain read for polling; data taken in the answer cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    v = reg_rdata;
  endtask
  // fifo reset pulses are one cycle wide, so counting edges is exact
  task automatic count_rst(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(posedge clk);
      if (fifo_rst_o === 1'b1) c++;
    end
  endtask
  task automatic wait_irq(input int n);
    int i;
    i = 0;
    while (irq !== 1'b1 && i < n) begin
      @(posedge clk);
      i++;
    end
    if (irq !== 1'b1) begin
      mismatches++;
      $display("[ERR] %0t irq never rose", $time);
      test_done;
    end
  endtask
  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    $display("[ERR] %0t run timed out", $time);
    test_done;
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    // reset values, control readback, unmapped place
    rd_chk(ADDR_CTRL, 8'hff, CTRL_RESET, "ctrl reset");
    rd_chk(ADDR_IRQ_MASK, 8'hff, {5'h0, MASK_RESET}, "mask reset");
    rd_chk(ADDR_IRQ_STAT, 8'hff, 8'h00, "events reset");
    wr(8'h10, 8'hff);
    rd_chk(8'h10, 8'hff, 8'h00, "unmapped read");
    wr(ADDR_CTRL, 8'h0e);
    rd_chk(ADDR_CTRL, 8'h0f, 8'h0e, "ctrl readback");
    wr(ADDR_CTRL, 8'h00);
    // software fifo reset with sync off, event masked
    wr(ADDR_CMD, 8'h01);
    // watch from the strobe on: the zero phase stands for one cycle only
    fork
      count_rst(3, k);
      begin
        n0 = 0;
        repeat (12) begin
          @(posedge clk);
          if (clk_phase_o === PHASE_ZERO) n0++;
        end
      end
    join
    chk(8'(k), 8'h01, "cmd fifo reset pulse");
    chk({7'h0, n0 > 0}, 8'h01, "phase not aligned to link");
    chk({7'h0, irq}, 8'h00, "masked event drove irq");
    wr(ADDR_IRQ_MASK, 8'h04);
    wait_irq(4);
    rd_chk(ADDR_IRQ_STAT, 8'hff, 8'h04, "fifo event");
    repeat (2) @(posedge clk);
    chk({7'h0, irq}, 8'h00, "irq after clear");
    // one-shot sync on falling capture
    wr(ADDR_IRQ_MASK, 8'h03);
    wr(ADDR_CTRL, 8'h01);
    fork
      src.one_frame(3);
      count_rst(60, k);
    join
    chk(8'(k), 8'h01, "frame fifo reset");
    wait_irq(200);
    rd_chk(ADDR_IRQ_STAT, 8'hff, 8'h05, "sync events");
    rd_chk(ADDR_STATUS, 8'h03, 8'h01, "sync done");
    // later frames are ignored once locked
    fork
      src.one_frame(3);
      count_rst(60, k);
    join
    chk(8'(k), 8'h00, "one-shot resynced");
    rd_chk(ADDR_STATUS, 8'h03, 8'h01, "lock kept");
    // a bad sync ratio must be flagged as lost lock
    sync_fast <= 1'b1;
    wait_irq(300);
    rd_chk(ADDR_IRQ_STAT, 8'h03, 8'h02, "lock lost event");
    rd_chk(ADDR_STATUS, 8'h03, 8'h03, "lock lost status");
    sync_fast <= 1'b0;
    // sync engine off: frames do not act
    wr(ADDR_CTRL, 8'h00);
    fork
      src.one_frame(3);
      count_rst(60, k);
    join
    chk(8'(k), 8'h00, "frame acted with sync off");
    rd_chk(ADDR_STATUS, 8'h01, 8'h00, "done kept with sync off");
    // continuous frames, byte mode, rising capture
    wr(ADDR_CTRL, 8'h0f);
    frame_cont <= 1'b1;
    count_rst(300, k);
    chk({7'h0, k >= 3}, 8'h01, "continuous resets");
    // done stands only from the sync hit to the next frame, so poll for it
    d = 8'h00;
    k = 0;
    while (d[0] !== 1'b1 && k < 40) begin
      rd(ADDR_STATUS, d);
      k++;
    end
    chk(d & 8'h03, 8'h01, "continuous lock");
    // back-to-back event reads: a fifo reset that meets a clearing read
    // must still be reported by the next one
    acc = 8'h00;
    @(posedge clk);
    reg_addr <= ADDR_IRQ_STAT;
    reg_rd <= 1'b1;
    repeat (80) begin
      @(posedge clk);
      acc = acc | reg_rdata;
    end
    reg_rd <= 1'b0;
    chk(acc & 8'h04, 8'h04, "fifo event lost by read");
    frame_cont <= 1'b0;
    test_done;
  end
endmodule
